// ==== logic/pts_params.svh ====
`ifndef PTS_PARAMS_SVH
`define PTS_PARAMS_SVH
`define PTS_CLK_HZ 40000000
`define PTS_CYCLE_US 1000
`define PTS_WINDOW_MS 20
`define PTS_CH 3
`define PTS_DLY_W 21
`define PTS_FRAC 64'sh0000000000002710
`define PTS_PCT_DIV 64'sh00000000000F4240
`define PTS_PU_RST 32'h00000064
`define PTS_HYST_RST 32'h00007530
`define PTS_MULT_RST 32'h00002710
`define PTS_OPD_RST 21'h000028
`define PTS_RLD_RST 21'h00003C
`define PTS_CNT_RST 2'h1
`define PTS_DIV_STEPS 6'h30
`define PTS_A_CTRL 8'h00
`define PTS_A_PU 8'h04
`define PTS_A_HY 8'h14
`define PTS_A_BL 8'h20
`define PTS_A_MU 8'h2C
`define PTS_A_OPD 8'h38
`define PTS_A_RLD 8'h3C
`define PTS_A_STAT 8'h40
`define PTS_A_REM 8'h44
`define PTS_A_EXP 8'h48
`define PTS_A_SC 8'h4C
`define PTS_A_RAT 8'h58
`define PTS_F_CNT 1:0
`define PTS_F_MODE 2
`endif

// ==== logic/pts_pkg.sv ====
package pts_pkg;
	typedef enum logic [2:0] {
		PTS_OVER = 3'b000,
		PTS_OVER_ABS = 3'b001,
		PTS_UNDER = 3'b010,
		PTS_UNDER_ABS = 3'b011,
		PTS_DREL_DIR = 3'b100,
		PTS_DREL_ABS = 3'b101,
		PTS_DVAL_DIR = 3'b110,
		PTS_DVAL_ABS = 3'b111
	} pts_mode_t;
	typedef enum logic [1:0] {
		PTS_NORMAL = 2'b00,
		PTS_START = 2'b01,
		PTS_TRIP = 2'b10,
		PTS_BLOCKED = 2'b11
	} pts_cond_t;
	// Sign extension kept explicit so no width is padded silently
	function automatic logic signed [63:0] pts_sx(input logic [31:0] v);
		return {{32{v[31]}}, v};
	endfunction : pts_sx
	function automatic logic signed [63:0] pts_abs(input logic signed [63:0] v);
		return (v < 0) ? -v : v;
	endfunction : pts_abs
endpackage : pts_pkg

// ==== logic/pts_if.sv ====
`timescale 1ns/1ps
interface pts_ch_if import pts_pkg::*; ();
	logic [31:0] value;
	logic [31:0] pickup;
	logic [31:0] hyst;
	logic [31:0] blk_lim;
	pts_mode_t mode;
	logic tick;
	logic win;
	logic en;
	logic picked;
	modport top (output value, pickup, hyst, blk_lim, mode, tick, win, en, input picked);
	modport cmp (input value, pickup, hyst, blk_lim, mode, tick, win, en, output picked);
endinterface : pts_ch_if

interface pts_div_if ();
	logic start;
	logic [47:0] num;
	logic [31:0] den;
	logic done;
	logic [31:0] quo;
	modport top (output start, num, den, input done, quo);
	modport div (input start, num, den, output done, quo);
endinterface : pts_div_if

// ==== logic/pts_cmp.sv ====
`timescale 1ns/1ps
`include "pts_params.svh"
module pts_cmp import pts_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Channel
	pts_ch_if.cmp ch
);
	typedef struct packed {
		logic [31:0] snap;
		logic picked;
	} pts_cmp_st_t;
	pts_cmp_st_t st_reg;
	pts_cmp_st_t st_next;
	logic signed [63:0] val;
	logic signed [63:0] pu;
	logic signed [63:0] dlt;
	logic signed [63:0] thr;
	logic signed [63:0] lhs;
	logic signed [63:0] rhs;
	logic signed [63:0] hm;
	logic under;
	logic lim_ok;
	////////////////////////////////////////////////////////////////
	// Every mode folds into one greater-than test with hysteresis
	always_comb begin
		st_next = st_reg;
		val = pts_sx(ch.value);
		pu = pts_sx(ch.pickup);
		dlt = val - pts_sx(st_reg.snap);
		thr = pts_abs((pts_abs(pts_sx(st_reg.snap)) * pu) / `PTS_PCT_DIV);
		under = (ch.mode == PTS_UNDER) || (ch.mode == PTS_UNDER_ABS);
		unique case (ch.mode)
			PTS_OVER: begin lhs = val; rhs = pu; end
			PTS_OVER_ABS: begin lhs = pts_abs(val); rhs = pu; end
			PTS_UNDER: begin lhs = -val; rhs = -pu; end
			PTS_UNDER_ABS: begin lhs = -pts_abs(val); rhs = -pu; end
			PTS_DREL_DIR: begin lhs = (pu < 0) ? -dlt : dlt; rhs = thr; end
			PTS_DREL_ABS: begin lhs = pts_abs(dlt); rhs = thr; end
			PTS_DVAL_DIR: begin lhs = (pu < 0) ? -dlt : dlt; rhs = pts_abs(pu); end
			PTS_DVAL_ABS: begin lhs = pts_abs(dlt); rhs = pts_abs(pu); end
		endcase
		hm = (pts_abs(rhs) * pts_sx(ch.hyst)) / `PTS_PCT_DIV;
		lim_ok = !under || (val >= pts_sx(ch.blk_lim));
		if (ch.tick) begin
			// Held pick-up drops once past the margin, or at once if disabled or, in under modes, below blocking limit
			st_next.picked = ch.en && lim_ok && (st_reg.picked ? (lhs > rhs - hm) : (lhs > rhs));
			if (ch.win) begin
				st_next.snap = ch.value;
			end
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
	assign ch.picked = st_reg.picked;
	////////////////////////////////////////////////////////////////
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_over_pick: assert property (ch.tick && ch.en && ch.mode == PTS_OVER && val > pu |=> ch.picked)
		else $error("over mode missed pick-up");
	a_under_limit: assert property (ch.tick && under && val < pts_sx(ch.blk_lim) |=> !ch.picked)
		else $error("under mode active below blocking limit");
	a_under_pick: assert property (ch.tick && ch.en && ch.mode == PTS_UNDER && val < pu
		&& val >= pts_sx(ch.blk_lim) |=> ch.picked)
		else $error("under mode missed pick-up");
	a_dval_abs: assert property (ch.tick && ch.en && ch.mode == PTS_DVAL_ABS && pts_abs(dlt) > pts_abs(pu)
		|=> ch.picked)
		else $error("absolute change missed pick-up");
endmodule : pts_cmp

// ==== logic/pts_div.sv ====
`timescale 1ns/1ps
`include "pts_params.svh"
module pts_div (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Divide port
	pts_div_if.div dv
);
	typedef struct packed {
		logic busy;
		logic done;
		logic [5:0] cnt;
		logic [32:0] rem;
		logic [47:0] quo;
		logic [31:0] den;
	} pts_div_st_t;
	pts_div_st_t st_reg;
	pts_div_st_t st_next;
	logic [32:0] sh;
	logic [32:0] trial;
	////////////////////////////////////////////////////////////////
	// Restoring divide, one quotient bit per clock
	always_comb begin
		st_next = st_reg;
		st_next.done = 1'b0;
		sh = {st_reg.rem[31:0], st_reg.quo[47]};
		trial = sh - {1'b0, st_reg.den};
		if (!st_reg.busy) begin
			if (dv.start) begin
				st_next.busy = 1'b1;
				st_next.cnt = `PTS_DIV_STEPS;
				st_next.rem = '0;
				st_next.quo = dv.num;
				st_next.den = dv.den;
			end
		end else begin
			st_next.rem = trial[32] ? sh : trial;
			st_next.quo = {st_reg.quo[46:0], ~trial[32]};
			st_next.cnt = st_reg.cnt - 6'h01;
			if (st_reg.cnt == 6'h01) begin
				st_next.busy = 1'b0;
				st_next.done = 1'b1;
			end
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
	// Saturate rather than wrap a ratio that is too large
	assign dv.quo = (st_reg.quo[47:31] != '0) ? 32'h7FFFFFFF : st_reg.quo[31:0];
	assign dv.done = st_reg.done;
endmodule : pts_div

// ==== logic/pts_stage.sv ====
`timescale 1ns/1ps
`include "pts_params.svh"
module pts_stage import pts_pkg::*; #(
	parameter int TICK_CYCLES = `PTS_CLK_HZ / 1000000 * `PTS_CYCLE_US,
	parameter int WIN_TICKS = `PTS_WINDOW_MS * 1000 / `PTS_CYCLE_US
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Register bus
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Measurements and blocking
	input wire logic [31:0] measured_magnitude_one,
	input wire logic [31:0] measured_magnitude_two,
	input wire logic [31:0] measured_magnitude_three,
	input wire logic [31:0] calculated_magnitude,
	input wire logic block_in,
	// Stage outputs
	output logic start_out,
	output logic trip_out,
	output logic blocked_out
);
	localparam int TW = $clog2(TICK_CYCLES) + 1;
	localparam int WW = $clog2(WIN_TICKS) + 1;
	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
		logic [1:0] cnt;
		logic [2:0][2:0] mode;
		logic [3:0][31:0] pu;
		logic [2:0][31:0] hy;
		logic [2:0][31:0] bl;
		logic [2:0][31:0] mu;
		logic [2:0][31:0] sc;
		logic [3:0][31:0] rat;
		logic [`PTS_DLY_W-1:0] opd;
		logic [`PTS_DLY_W-1:0] rld;
		logic [`PTS_DLY_W-1:0] opc;
		logic [`PTS_DLY_W-1:0] rlc;
		pts_cond_t cond;
		logic [TW-1:0] tck;
		logic [WW-1:0] wcnt;
		logic tick;
		logic win;
		logic blk;
		logic [1:0] ri;
		logic pend;
		logic dgo;
	} pts_top_st_t;
	// Defaults: count 1, over mode, pick-up 0.01, 3 %, unit multiplier
	localparam pts_top_st_t ST_RST = '{
		cnt: `PTS_CNT_RST,
		pu: {4{`PTS_PU_RST}},
		hy: {3{`PTS_HYST_RST}},
		mu: {3{`PTS_MULT_RST}},
		opd: `PTS_OPD_RST,
		rld: `PTS_RLD_RST,
		cond: PTS_NORMAL,
		default: '0
	};
	pts_top_st_t st_reg;
	pts_top_st_t st_next;
	logic rst_meta;
	logic rst_n;
	logic [2:0][31:0] meas;
	logic [2:0] picked;
	logic [2:0] en;
	logic pick;
	logic [31:0] src;
	logic [63:0] num_full;
	logic [63:0] den_full;
	logic [`PTS_DLY_W-1:0] remain;
	pts_ch_if ch_if[`PTS_CH] ();
	pts_div_if div_if ();

	////////////////////////////////////////////////////////////////
	// Helpers
	function automatic logic in_rng(input logic [7:0] a, input logic [7:0] base, input logic [2:0] n);
		return (a >= base) && (a < base + {3'h0, n, 2'b00});
	endfunction : in_rng
	function automatic logic [1:0] idx(input logic [7:0] a, input logic [7:0] base);
		logic [7:0] off;
		off = a - base;
		return off[3:2];
	endfunction : idx
	function automatic logic [31:0] scale(input logic [31:0] m, input logic [31:0] k);
		logic signed [63:0] p;
		p = (pts_sx(m) * pts_sx(k)) / `PTS_FRAC;
		return p[31:0];
	endfunction : scale

	////////////////////////////////////////////////////////////////
	// Reset release through two flops
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	////////////////////////////////////////////////////////////////
	// Comparator channels
	assign meas = {measured_magnitude_three, measured_magnitude_two, measured_magnitude_one};
	for (genvar g = 0; g < `PTS_CH; g++) begin : g_ch
		assign en[g] = (2'(g) < st_reg.cnt);
		assign ch_if[g].value = st_reg.sc[g];
		assign ch_if[g].pickup = st_reg.pu[g];
		assign ch_if[g].hyst = st_reg.hy[g];
		assign ch_if[g].blk_lim = st_reg.bl[g];
		assign ch_if[g].mode = pts_mode_t'(st_reg.mode[g]);
		assign ch_if[g].tick = st_reg.tick;
		assign ch_if[g].win = st_reg.win;
		assign ch_if[g].en = en[g];
		assign picked[g] = ch_if[g].picked;
		pts_cmp u_cmp (
			.clk(ref_clk),
			.rst_n(rst_n),
			.ch(ch_if[g])
		);
	end
	// Channels are independent; any one picking starts the stage
	assign pick = |(picked & en);

	////////////////////////////////////////////////////////////////
	// Shared divider for the four ratios, one at a time
	assign src = (st_reg.ri == 2'h3) ? calculated_magnitude : st_reg.sc[st_reg.ri];
	assign num_full = pts_abs(pts_sx(src)) * `PTS_FRAC;
	assign den_full = pts_abs(pts_sx(st_reg.pu[st_reg.ri]));
	assign div_if.start = st_reg.dgo;
	assign div_if.num = num_full[47:0];
	assign div_if.den = den_full[31:0];
	pts_div u_div (
		.clk(ref_clk),
		.rst_n(rst_n),
		.dv(div_if)
	);

	// Time left while counting toward trip
	assign remain = (st_reg.cond == PTS_START) ? st_reg.opd - st_reg.opc : '0;

	////////////////////////////////////////////////////////////////
	// Register readback
	function automatic logic [31:0] rd_mux(input pts_top_st_t s, input logic [7:0] a,
		input logic [`PTS_DLY_W-1:0] rem, input logic [2:0] pk);
		logic [31:0] d;
		d = '0;
		if (a == `PTS_A_CTRL) begin
			d = {21'h0, s.mode, s.cnt};
		end else if (in_rng(a, `PTS_A_PU, 3'h4)) begin
			d = s.pu[idx(a, `PTS_A_PU)];
		end else if (in_rng(a, `PTS_A_HY, 3'h3)) begin
			d = s.hy[idx(a, `PTS_A_HY)];
		end else if (in_rng(a, `PTS_A_BL, 3'h3)) begin
			d = s.bl[idx(a, `PTS_A_BL)];
		end else if (in_rng(a, `PTS_A_MU, 3'h3)) begin
			d = s.mu[idx(a, `PTS_A_MU)];
		end else if (a == `PTS_A_OPD) begin
			d = {11'h0, s.opd};
		end else if (a == `PTS_A_RLD) begin
			d = {11'h0, s.rld};
		end else if (a == `PTS_A_STAT) begin
			d = {26'h0, s.blk, pk, s.cond};
		end else if (a == `PTS_A_REM) begin
			d = {11'h0, rem};
		end else if (a == `PTS_A_EXP) begin
			d = {11'h0, s.opd};
		end else if (in_rng(a, `PTS_A_SC, 3'h3)) begin
			d = s.sc[idx(a, `PTS_A_SC)];
		end else if (in_rng(a, `PTS_A_RAT, 3'h4)) begin
			d = s.rat[idx(a, `PTS_A_RAT)];
		end
		return d;
	endfunction : rd_mux

	////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		st_next = st_reg;
		st_next.tick = 1'b0;
		st_next.win = 1'b0;
		st_next.dgo = 1'b0;
		// Program cycle and 20 ms window strobes
		if (st_reg.tck == TW'(TICK_CYCLES - 1)) begin
			st_next.tck = '0;
			st_next.tick = 1'b1;
			if (st_reg.wcnt == WW'(WIN_TICKS - 1)) begin
				st_next.wcnt = '0;
				st_next.win = 1'b1;
			end else begin
				st_next.wcnt = st_reg.wcnt + 1'b1;
			end
		end else begin
			st_next.tck = st_reg.tck + 1'b1;
		end
		// Bus: one wait state, then the access completes
		st_next.ack = 1'b0;
		if ((avs_read || avs_write) && !st_reg.ack) begin
			st_next.ack = 1'b1;
			st_next.rdata = rd_mux(st_reg, avs_address, remain, picked);
		end
		if (avs_write && st_reg.ack) begin
			if (avs_address == `PTS_A_CTRL) begin
				st_next.cnt = avs_writedata[`PTS_F_CNT];
				st_next.mode = avs_writedata[`PTS_F_MODE +: 9];
			end else if (in_rng(avs_address, `PTS_A_PU, 3'h4)) begin
				st_next.pu[idx(avs_address, `PTS_A_PU)] = avs_writedata;
			end else if (in_rng(avs_address, `PTS_A_HY, 3'h3)) begin
				st_next.hy[idx(avs_address, `PTS_A_HY)] = avs_writedata;
			end else if (in_rng(avs_address, `PTS_A_BL, 3'h3)) begin
				st_next.bl[idx(avs_address, `PTS_A_BL)] = avs_writedata;
			end else if (in_rng(avs_address, `PTS_A_MU, 3'h3)) begin
				st_next.mu[idx(avs_address, `PTS_A_MU)] = avs_writedata;
			end else if (avs_address == `PTS_A_OPD) begin
				st_next.opd = avs_writedata[`PTS_DLY_W-1:0];
			end else if (avs_address == `PTS_A_RLD) begin
				st_next.rld = avs_writedata[`PTS_DLY_W-1:0];
			end
		end
		// Ratio round robin; a zero level or unfollowed channel reads zero
		if (!st_reg.pend) begin
			st_next.dgo = 1'b1;
			st_next.pend = 1'b1;
		end else if (div_if.done) begin
			st_next.pend = 1'b0;
			st_next.ri = st_reg.ri + 2'h1;
			if (st_reg.pu[st_reg.ri] == '0 || (st_reg.ri != 2'h3 && !en[st_reg.ri])) begin
				st_next.rat[st_reg.ri] = '0;
			end else if (src[31] ^ st_reg.pu[st_reg.ri][31]) begin
				st_next.rat[st_reg.ri] = -div_if.quo;
			end else begin
				st_next.rat[st_reg.ri] = div_if.quo;
			end
		end
		// Once per program cycle: scale, sample block, step the timer
		if (st_reg.tick) begin
			st_next.blk = block_in;
			for (int i = 0; i < `PTS_CH; i++) begin
				st_next.sc[i] = scale(meas[i], st_reg.mu[i]);
			end
			unique case (st_reg.cond)
				PTS_NORMAL: begin
					st_next.opc = '0;
					st_next.rlc = '0;
					if (pick) begin
						st_next.cond = block_in ? PTS_BLOCKED : PTS_START;
					end
				end
				PTS_START: begin
					if (block_in) begin
						// Start drops at once; counter restarts
						st_next.cond = PTS_BLOCKED;
						st_next.opc = '0;
						st_next.rlc = '0;
					end else if (pick) begin
						st_next.rlc = '0;
						if (st_reg.opc + 1'b1 >= st_reg.opd) begin
							st_next.cond = PTS_TRIP;
							st_next.opc = st_reg.opd;
						end else begin
							st_next.opc = st_reg.opc + 1'b1;
						end
					end else if (st_reg.rlc + 1'b1 >= st_reg.rld) begin
						st_next.cond = PTS_NORMAL;
						st_next.opc = '0;
						st_next.rlc = '0;
					end else begin
						st_next.rlc = st_reg.rlc + 1'b1;
					end
				end
				PTS_TRIP: begin
					// Block acts on trip as a dropped pick-up would
					if (pick && !block_in) begin
						st_next.rlc = '0;
					end else if (st_reg.rlc + 1'b1 >= st_reg.rld) begin
						st_next.cond = PTS_NORMAL;
						st_next.opc = '0;
						st_next.rlc = '0;
					end else begin
						st_next.rlc = st_reg.rlc + 1'b1;
					end
				end
				PTS_BLOCKED: begin
					if (!pick) begin
						st_next.cond = PTS_NORMAL;
					end else if (!block_in) begin
						st_next.cond = PTS_START;
						st_next.opc = '0;
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= ST_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// Outputs
	assign avs_readdata = st_reg.rdata;
	assign avs_waitrequest = (avs_read || avs_write) && !st_reg.ack;
	assign start_out = (st_reg.cond == PTS_START) || (st_reg.cond == PTS_TRIP);
	assign trip_out = (st_reg.cond == PTS_TRIP);
	assign blocked_out = (st_reg.cond == PTS_BLOCKED);

	////////////////////////////////////////////////////////////////
	// Checks
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	a_trip_from_start: assert property (st_reg.cond == PTS_TRIP && $past(st_reg.cond) != PTS_TRIP
		|-> $past(st_reg.cond) == PTS_START)
		else $error("trip entered without start");
	a_trip_on_delay: assert property (st_reg.tick && st_reg.cond == PTS_START && pick && !block_in
		&& st_reg.opc + 1'b1 >= st_reg.opd |=> trip_out)
		else $error("trip late after operating delay");
	a_pick_blocked: assert property (st_reg.tick && st_reg.cond == PTS_NORMAL && pick && block_in
		|=> blocked_out && !start_out)
		else $error("blocked pick-up gave start");
	a_block_drops_start: assert property (st_reg.tick && st_reg.cond == PTS_START && block_in
		|=> !start_out)
		else $error("start held under block");
	a_remain_idle: assert property (st_reg.cond != PTS_START |-> remain == '0)
		else $error("remaining time shown while idle");
	a_remain_range: assert property (st_reg.cond == PTS_START |-> remain >= 1 && remain <= st_reg.opd)
		else $error("remaining time out of range");
	a_scale_value: assert property (st_reg.tick |=> st_reg.sc[0] == scale($past(measured_magnitude_one),
		$past(st_reg.mu[0])))
		else $error("scaled value wrong");
	a_bus_answer: assert property ((avs_read || avs_write) |-> ##[0:1] !avs_waitrequest)
		else $error("bus access not answered");
	c_trip: cover property (st_reg.cond == PTS_START ##1 st_reg.cond == PTS_TRIP);
	c_blocked: cover property (st_reg.cond == PTS_NORMAL ##1 st_reg.cond == PTS_BLOCKED);
	c_release: cover property (st_reg.cond == PTS_TRIP ##1 st_reg.cond == PTS_NORMAL);
endmodule : pts_stage

// ==== test/pts_meas_model.sv ====
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////
// Measurement subsystem and blocking matrix seen by the stage
module pts_meas_model (
	// Commands from the bench
	input wire logic [31:0] set_val [4],
	input wire logic set_blk,
	// Towards the stage
	output logic [31:0] measured_magnitude_one,
	output logic [31:0] measured_magnitude_two,
	output logic [31:0] measured_magnitude_three,
	output logic [31:0] calculated_magnitude,
	output logic block_in
);
	// Values only move just after a rising edge, as the bench drives them
	assign measured_magnitude_one = set_val[0];
	assign measured_magnitude_two = set_val[1];
	assign measured_magnitude_three = set_val[2];
	assign calculated_magnitude = set_val[3];
	// Block follows the bench command directly, with no delay of its own
	assign block_in = set_blk;
endmodule : pts_meas_model

// ==== test/pts_stage_tb.sv ====
`timescale 1ns/1ps
`include "pts_params.svh"
module pts_stage_tb import pts_pkg::*; ;
	localparam int TK = 4;
	localparam int LIM = 900;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] adr = 8'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [31:0] rdata, q, m1, m2, m3, mc;
	logic waitreq, st, tr, bl, blk;
	logic [31:0] sv [4] = '{default: 32'h0};
	logic sb = 1'b0;
	int errors = 0;
	int checks_done = 0;
	int n, s0;
	int cyc = 0;
	wire [2:0] o = {bl, tr, st};
	////////////////////////////////////////////////////////////////
	// Clock and cycle stamp
	initial begin
		forever #12.5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) cyc <= cyc + 1;
	// Short program tick keeps delays to a few hundred cycles
	pts_stage #(.TICK_CYCLES(TK), .WIN_TICKS(20)) DUT (.ref_clk(ref_clk), .nrst(nrst),
		.avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
		.avs_readdata(rdata), .avs_waitrequest(waitreq),
		.measured_magnitude_one(m1), .measured_magnitude_two(m2),
		.measured_magnitude_three(m3), .calculated_magnitude(mc), .block_in(blk),
		.start_out(st), .trip_out(tr), .blocked_out(bl));
	pts_meas_model model (.set_val(sv), .set_blk(sb), .measured_magnitude_one(m1),
		.measured_magnitude_two(m2), .measured_magnitude_three(m3),
		.calculated_magnitude(mc), .block_in(blk));
	////////////////////////////////////////////////////////////////
	task results;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : results
	task chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	// Request holds until waitrequest is sampled low at an edge
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge ref_clk);
		adr <= a;
		wd <= d;
		rd <= !w;
		wr <= w;
		do begin
			@(posedge ref_clk);
			k++;
		end while (waitreq !== 1'b0 && k < 50);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		if (k >= 50) begin
			errors++;
			results();
		end
	endtask : bus
	task rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(q & m, e);
	endtask : rc
	task ms(input int c, input logic [31:0] v);
		@(posedge ref_clk);
		sv[c] <= v;
	endtask : ms
	task bk(input logic v);
		@(posedge ref_clk);
		sb <= v;
	endtask : bk
	// Bounded wait for one stage output to reach a level
	task wt(input int i, input logic v);
		n = 0;
		while (o[i] !== v && n < LIM) begin
			@(posedge ref_clk);
			n++;
		end
		if (n >= LIM) begin
			errors++;
			results();
		end
	endtask : wt
	////////////////////////////////////////////////////////////////
	task t_reset;
		rc(`PTS_A_CTRL, 32'hFFFFFFFF, 32'h1);
		rc(`PTS_A_PU, 32'hFFFFFFFF, 32'h64);
		rc(`PTS_A_HY, 32'hFFFFFFFF, 32'h7530);
		rc(`PTS_A_OPD, 32'hFFFFFFFF, 32'h28);
		rc(`PTS_A_RLD, 32'hFFFFFFFF, 32'h3C);
		rc(`PTS_A_EXP, 32'hFFFFFFFF, 32'h28);
		bus(1'b1, `PTS_A_STAT, 32'hFFFFFFFF);
		bus(1'b1, 8'hFC, 32'hFFFFFFFF);
		rc(`PTS_A_STAT, 32'hFFFFFFFF, 32'h0);
		rc(8'hFC, 32'hFFFFFFFF, 32'h0);
		for (int m = 0; m < 8; m++) begin
			bus(1'b1, `PTS_A_CTRL, 32'(m << 2) | 32'h1);
			rc(`PTS_A_CTRL, 32'hFFFFFFFF, 32'(m << 2) | 32'h1);
		end
		bus(1'b1, `PTS_A_CTRL, 32'h1);
		// Under modes picked at zero input; let that start run out first
		wt(0, 1'b0);
		$display("test reset done");
	endtask : t_reset
	task t_trip;
		bus(1'b1, `PTS_A_OPD, 32'h8);
		bus(1'b1, `PTS_A_RLD, 32'h6);
		ms(3, 32'hC8);
		ms(0, 32'h100);
		wt(0, 1'b1);
		s0 = cyc;
		rc(`PTS_A_STAT, 32'h3, 32'(PTS_START));
		bus(1'b0, `PTS_A_REM, 32'h0);
		chk(32'(q > 0 && q <= 8), 32'h1);
		rc(`PTS_A_EXP, 32'hFFFFFFFF, 32'h8);
		wt(1, 1'b1);
		chk(32'(cyc - s0 >= 7 * TK && cyc - s0 <= 9 * TK), 32'h1);
		rc(`PTS_A_STAT, 32'h3, 32'(PTS_TRIP));
		rc(`PTS_A_SC, 32'hFFFFFFFF, 32'h100);
		// Ratios refresh round robin; wait out a full lap plus one
		repeat (80 * TK) @(posedge ref_clk);
		rc(`PTS_A_RAT, 32'hFFFFFFFF, 32'h6400);
		rc(`PTS_A_RAT + 8'h0C, 32'hFFFFFFFF, 32'h4E20);
		bus(1'b1, `PTS_A_MU, 32'h4E20);
		ms(0, 32'h0);
		s0 = cyc;
		wt(0, 1'b0);
		chk(32'(cyc - s0 >= 5 * TK && cyc - s0 <= 10 * TK), 32'h1);
		rc(`PTS_A_SC, 32'hFFFFFFFF, 32'h0);
		ms(0, 32'h80);
		repeat (4 * TK) @(posedge ref_clk);
		rc(`PTS_A_SC, 32'hFFFFFFFF, 32'h100);
		bus(1'b1, `PTS_A_MU, 32'h2710);
		ms(0, 32'h0);
		wt(0, 1'b0);
		$display("test trip done");
	endtask : t_trip
	// Value inside the hysteresis band must keep the pick
	task t_hyst;
		bus(1'b1, `PTS_A_PU, 32'h2710);
		ms(0, 32'h2774);
		wt(0, 1'b1);
		ms(0, 32'h2648);
		repeat (10 * TK) @(posedge ref_clk);
		rc(`PTS_A_STAT, 32'h4, 32'h4);
		ms(0, 32'h2328);
		wt(0, 1'b0);
		rc(`PTS_A_STAT, 32'h4, 32'h0);
		bus(1'b1, `PTS_A_PU, 32'h64);
		$display("test hysteresis done");
	endtask : t_hyst
	task t_under;
		bus(1'b1, `PTS_A_CTRL, 32'h9);
		bus(1'b1, `PTS_A_BL, 32'h10);
		ms(0, 32'h8);
		repeat (10 * TK) @(posedge ref_clk);
		rc(`PTS_A_STAT, 32'h7, 32'h0);
		ms(0, 32'h30);
		wt(0, 1'b1);
		rc(`PTS_A_STAT, 32'h4, 32'h4);
		ms(0, 32'h200);
		wt(0, 1'b0);
		bus(1'b1, `PTS_A_CTRL, 32'h1);
		$display("test under done");
	endtask : t_under
	task t_block;
		bk(1'b1);
		ms(0, 32'h100);
		wt(2, 1'b1);
		chk({31'h0, st}, 32'h0);
		rc(`PTS_A_STAT, 32'h23, 32'h23);
		bk(1'b0);
		wt(0, 1'b1);
		bk(1'b1);
		wt(0, 1'b0);
		chk({31'h0, bl}, 32'h1);
		ms(0, 32'h0);
		bk(1'b0);
		wt(2, 1'b0);
		$display("test block done");
	endtask : t_block
	// Unfollowed channel stays quiet until the count takes it in
	task t_chan;
		ms(1, 32'h100);
		repeat (10 * TK) @(posedge ref_clk);
		rc(`PTS_A_STAT, 32'hF, 32'h0);
		bus(1'b1, `PTS_A_CTRL, 32'h2);
		wt(0, 1'b1);
		rc(`PTS_A_STAT, 32'hC, 32'h8);
		ms(1, 32'h0);
		wt(0, 1'b0);
		bus(1'b1, `PTS_A_CTRL, 32'h1);
		$display("test channels done");
	endtask : t_chan
	// Negative value: signed over stays quiet, absolute over picks
	task t_abs;
		ms(0, 32'hFFFFFF00);
		repeat (10 * TK) @(posedge ref_clk);
		rc(`PTS_A_STAT, 32'h7, 32'h0);
		rc(`PTS_A_SC, 32'hFFFFFFFF, 32'hFFFFFF00);
		bus(1'b1, `PTS_A_CTRL, 32'h5);
		wt(0, 1'b1);
		rc(`PTS_A_STAT, 32'h4, 32'h4);
		ms(0, 32'h0);
		wt(0, 1'b0);
		bus(1'b1, `PTS_A_CTRL, 32'h1);
		$display("test absolute done");
	endtask : t_abs
	// Step change against a snapshot taken before it
	task t_delta;
		bus(1'b1, `PTS_A_CTRL, 32'h1D);
		repeat (25 * TK) @(posedge ref_clk);
		// A change smaller than the pick-up amount must not pick
		ms(0, 32'h40);
		repeat (4 * TK) @(posedge ref_clk);
		rc(`PTS_A_STAT, 32'h7, 32'h0);
		ms(0, 32'h200);
		wt(0, 1'b1);
		rc(`PTS_A_STAT, 32'h3, 32'(PTS_START));
		ms(0, 32'h0);
		wt(0, 1'b0);
		bus(1'b1, `PTS_A_CTRL, 32'h1);
		$display("test delta done");
	endtask : t_delta
	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (12) @(posedge ref_clk);
		nrst <= 1'b1;
		repeat (3) @(posedge ref_clk);
		t_reset();
		t_trip();
		t_hyst();
		t_under();
		t_block();
		t_chan();
		t_abs();
		t_delta();
		results();
	end
endmodule : pts_stage_tb
